//--- design/ascdr_conv_timer.sv
// Conversion period timer counting master clock ticks
`timescale 1ns/1ps
module ascdr_conv_timer
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic tick_in,
	input wire logic restart_in,
	input wire logic hold_in,
	input wire logic [23:0] period_in,
	// Result
	output logic done_out
);

	// ==========================================================
	// Counter
	logic [23:0] count_q, count_d;
	logic done_q, done_d;

	always_comb
	begin
		count_d = count_q;
		done_d = 1'b0;
		if (hold_in || restart_in)
			count_d = 24'h00_0000;
		else if (tick_in)
		begin
			if (count_q >= period_in - 24'h00_0001)
			begin
				count_d = 24'h00_0000;
				done_d = 1'b1;
			end
			else
				count_d = count_q + 24'h00_0001;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			count_q <= 24'h00_0000;
			done_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			done_q <= done_d;
		end
	end

	assign done_out = done_q;

endmodule

//--- design/ascdr_pkg.sv
// Shared constants, register layouts and types of the converter control block
package ascdr_pkg;

	// ==========================================================
	// Register selection codes of the command byte
	localparam logic [2:0] REG_COMM = 3'h0;
	localparam logic [2:0] REG_SETUP = 3'h1;
	localparam logic [2:0] REG_CLOCK = 3'h2;
	localparam logic [2:0] REG_DATA = 3'h3;
	localparam logic [2:0] REG_TEST = 3'h4;
	localparam logic [2:0] REG_NOP = 3'h5;
	localparam logic [2:0] REG_OFFSET = 3'h6;
	localparam logic [2:0] REG_GAIN = 3'h7;

	// ==========================================================
	// Field layouts, most significant bit first
	typedef struct packed {
		logic start_n;
		logic [2:0] register_select;
		logic read_select;
		logic power_down;
		logic [1:0] channel_select;
	} ascdr_cmd_s;

	typedef struct packed {
		logic [1:0] mode_select_bits;
		logic [2:0] gain_code;
		logic polarity_select;
		logic input_buffer_enable;
		logic filter_sync_hold;
	} ascdr_setup_s;

	typedef struct packed {
		logic id_bit;
		logic [1:0] fixed_zero;
		logic clock_output_disable;
		logic input_clock_halve;
		logic rate_family_select;
		logic [1:0] filter_rate_select;
	} ascdr_clock_s;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] SETUP_RESET = 8'h01;
	localparam logic [7:0] CLOCK_RESET = 8'h05;
	localparam logic [7:0] TEST_RESET = 8'h00;
	localparam logic [23:0] OFFSET_RESET = 24'h1f_4000;
	localparam logic [23:0] GAIN_RESET = 24'h57_61ab;

	// ==========================================================
	// Modes, result format and transfer lengths
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SELF = 2'h1;
	localparam logic [1:0] MODE_SYS_ZERO = 2'h2;
	localparam logic [1:0] MODE_SYS_FULL = 2'h3;
	localparam logic [15:0] UNIPOLAR_ZERO = 16'h0000;
	localparam logic [15:0] BIPOLAR_ZERO = 16'h1000;
	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_DATA = 5'h10;
	localparam logic [4:0] LEN_COEF = 5'h18;

	// ==========================================================
	// Timing: master clocks per modulator step and decimation by {rate family, filter rate}
	localparam int MOD_CYCLES_PER_WORD = 128;
	localparam logic [15:0] DEC_RATE [0:7] = '{16'h0187, 16'h0139, 16'h004e, 16'h0027,
		16'h0180, 16'h0140, 16'h004d, 16'h0026};

	typedef enum logic [1:0] {SER_CMD, SER_WRITE, SER_READ} ascdr_ser_e;
	typedef enum logic [1:0] {CAL_RUN, CAL_ZERO, CAL_FULL} ascdr_cal_e;

	// Amplifier gain is two to the power of the code
	function automatic logic [7:0] gain_decode(input logic [2:0] code);
		return 8'h01 << code;
	endfunction

	// Channel code to coefficient pair
	function automatic logic [1:0] pair_of(input logic [1:0] ch);
		return (ch == 2'h3) ? 2'h2 : {1'b0, ch[0] & ~ch[1]};
	endfunction

	// Bits transferred after the command byte
	function automatic logic [4:0] reg_len(input logic [2:0] rs);
		return (rs == REG_DATA) ? LEN_DATA : ((rs == REG_OFFSET || rs == REG_GAIN) ? LEN_COEF : LEN_BYTE);
	endfunction

	// Offset-corrected result word in unipolar or bipolar format
	function automatic logic [15:0] format_result(input logic [15:0] raw, input logic [23:0] off,
		input logic unipolar);
		logic [16:0] diff;
		diff = {1'b0, raw} - {1'b0, off[23:8]};
		if (unipolar)
			return diff[16] ? UNIPOLAR_ZERO : diff[15:0];
		return diff[15:0] + BIPOLAR_ZERO;
	endfunction

endpackage

//--- design/ascdr_top.sv
// Setup, clock, data and test registers with calibration sequencing and serial port
`timescale 1ns/1ps
// Operation
// - Setup byte: mode, gain code, polarity, buffer, sync hold; only sync hold resets high.
// - Mode 00 converts the channel chosen by the last command byte.
// - Mode 01: internal zero step, then reference full step; both coefficients written.
// - Finishing any calibration returns the mode bits to 00 by hardware.
// - Calibration request raises ready flag; it falls after completion with fresh data.
// - Mode 10: zero-scale on the external input, offset coefficient only.
// - Mode 11: full-scale on the present input, gain coefficient only.
// - Calibration uses the channel bits of the last command byte.
// - Amplifier gain is two to the power of the gain code.
// - Two fixed-zero clock bits read zero and ignore writes.
// - Output clock disable holds the clock pin low, else the clock runs out.
// - Clock halve divides the master clock by two.
// - Filter rate field, reset 01, sets decimation and word rate.
// - Data register writes consume sixteen bits and are discarded.
// - Read data changes on falling serial clock edges.
// - Unipolar zero reads 0x0000, bipolar zero reads 0x1000.
// - Sync hold high stops conversion and holds the filter timer in reset; a calibration in progress waits.
// - Every access except a write to the command or no-op register is a command byte then one transfer, then back to command.
// - Reset leaves setup at 0x01 and clock at 0x05, chosen by register select.
// - Clock byte: identifier, two zeros, disable, halve, rate family, filter rate.
module ascdr_top
	import ascdr_pkg::*;
#(
	parameter int CONV_SCALE = MOD_CYCLES_PER_WORD
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Serial port
	input wire logic serial_clk_in,
	input wire logic serial_data_in,
	input wire logic chip_select_n_in,
	output logic serial_data_out,
	output logic data_ready_n_out,
	// Clock pin
	output logic clock_output_pin_out,
	// Analog front end
	input wire logic [15:0] analog_code_in,
	output logic [1:0] channel_select_out,
	output logic [7:0] pga_gain_out,
	output logic input_buffer_enable_out,
	output logic input_short_out,
	output logic full_scale_ref_out,
	output logic modulator_hold_out,
	output logic power_down_out
);

	// ==========================================================
	// Declarations
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q, din_s1_q, din_s2_q, cs_s1_q, cs_s2_q;
	ascdr_ser_e ser_q, ser_d;
	logic [4:0] bit_q, bit_d, len_q, len_d;
	logic [23:0] shin_q, shin_d, shout_q, shout_d, wr_word, rd_word;
	logic dout_q, dout_d;
	ascdr_cmd_s cmd_q, cmd_d, new_cmd;
	logic sclk_rise, sclk_fall, cs_act, wr_stb, data_read_done;
	ascdr_setup_s setup_q, setup_d;
	ascdr_clock_s clock_q, clock_d, clk_wr;
	logic [7:0] test_q, test_d, pga_q, pga_d;
	logic half_q, half_d, clock_output_pin_q, clock_output_pin_d, tick;
	ascdr_cal_e cal_q, cal_d;
	logic cal_self_q, cal_self_d, data_ready_n_q, data_ready_n_d, short_q, short_d, fsref_q, fsref_d;
	logic [1:0] cal_ch_q, cal_ch_d, pair;
	logic [15:0] result_q, result_d;
	logic [23:0] offset_q [0:2];
	logic [23:0] offset_d [0:2];
	logic [23:0] gain_q [0:2];
	logic [23:0] gain_d [0:2];
	logic [23:0] period;
	logic conv_done, cal_request, cal_finish;

	// ==========================================================
	// Serial port
	assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
	assign cs_act = ~cs_s2_q;
	assign wr_word = {shin_q[22:0], din_s2_q};
	assign new_cmd = ascdr_cmd_s'(wr_word[7:0]);

	// Word loaded for a read, left aligned
	always_comb
	begin
		rd_word = 24'h00_0000;
		case (new_cmd.register_select)
			REG_COMM: rd_word = {data_ready_n_q, new_cmd[6:0], 16'h0000};
			REG_SETUP: rd_word = {setup_q, 16'h0000};
			REG_CLOCK: rd_word = {clock_q, 16'h0000};
			REG_DATA: rd_word = {result_q, 8'h00};
			REG_TEST: rd_word = {test_q, 16'h0000};
			REG_OFFSET: rd_word = offset_q[pair_of(new_cmd.channel_select)];
			REG_GAIN: rd_word = gain_q[pair_of(new_cmd.channel_select)];
			default: rd_word = 24'h00_0000;
		endcase
	end

	always_comb
	begin
		ser_d = ser_q;
		bit_d = bit_q;
		len_d = len_q;
		shin_d = shin_q;
		shout_d = shout_q;
		dout_d = dout_q;
		cmd_d = cmd_q;
		wr_stb = 1'b0;
		data_read_done = 1'b0;
		if (sclk_rise && cs_act)
		begin
			case (ser_q)
				SER_CMD:
				begin
					// A leading one is skipped until a start zero arrives
					if (bit_q != 5'h00 || din_s2_q == 1'b0)
					begin
						shin_d = wr_word;
						bit_d = bit_q + 5'h01;
						if (bit_q == LEN_BYTE - 5'h01)
						begin
							bit_d = 5'h00;
							cmd_d = new_cmd;
							len_d = reg_len(new_cmd.register_select);
							if (new_cmd.read_select)
							begin
								ser_d = SER_READ;
								shout_d = rd_word;
							end
							else if (new_cmd.register_select != REG_COMM && new_cmd.register_select != REG_NOP)
								ser_d = SER_WRITE;
						end
					end
				end
				SER_WRITE:
				begin
					shin_d = wr_word;
					bit_d = bit_q + 5'h01;
					if (bit_q == len_q - 5'h01)
					begin
						// All bits taken before returning to command wait
						bit_d = 5'h00;
						ser_d = SER_CMD;
						wr_stb = 1'b1;
					end
				end
				SER_READ:
				begin
					bit_d = bit_q + 5'h01;
					if (bit_q == len_q - 5'h01)
					begin
						bit_d = 5'h00;
						ser_d = SER_CMD;
						data_read_done = (cmd_q.register_select == REG_DATA);
					end
				end
				default: ser_d = SER_CMD;
			endcase
		end
		if (sclk_fall && cs_act && ser_q == SER_READ)
		begin
			dout_d = shout_q[23];
			shout_d = {shout_q[22:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			ser_q <= SER_CMD;
			bit_q <= 5'h00;
			len_q <= LEN_BYTE;
			shin_q <= 24'h00_0000;
			shout_q <= 24'h00_0000;
			dout_q <= 1'b0;
			cmd_q <= ascdr_cmd_s'(CMD_RESET);
		end
		else
		begin
			sclk_s1_q <= serial_clk_in;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			din_s1_q <= serial_data_in;
			din_s2_q <= din_s1_q;
			cs_s1_q <= chip_select_n_in;
			cs_s2_q <= cs_s1_q;
			ser_q <= ser_d;
			bit_q <= bit_d;
			len_q <= len_d;
			shin_q <= shin_d;
			shout_q <= shout_d;
			dout_q <= dout_d;
			cmd_q <= cmd_d;
		end
	end

	// ==========================================================
	// Setup, clock and test registers
	assign clk_wr = ascdr_clock_s'(wr_word[7:0]);

	always_comb
	begin
		setup_d = setup_q;
		clock_d = clock_q;
		test_d = test_q;
		if (cal_finish)
			setup_d.mode_select_bits = MODE_NORMAL;
		if (wr_stb)
		begin
			case (cmd_q.register_select)
				REG_SETUP: setup_d = ascdr_setup_s'(wr_word[7:0]);
				REG_CLOCK:
				begin
					// Identifier and fixed-zero bits keep their values
					clock_d.clock_output_disable = clk_wr.clock_output_disable;
					clock_d.input_clock_halve = clk_wr.input_clock_halve;
					clock_d.rate_family_select = clk_wr.rate_family_select;
					clock_d.filter_rate_select = clk_wr.filter_rate_select;
				end
				REG_TEST: test_d = wr_word[7:0];
				default: test_d = test_q;
			endcase
		end
		pga_d = gain_decode(setup_d.gain_code);
		half_d = ~half_q;
		clock_output_pin_d = clock_q.clock_output_disable ? 1'b0 : ~clock_output_pin_q;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			setup_q <= ascdr_setup_s'(SETUP_RESET);
			clock_q <= ascdr_clock_s'(CLOCK_RESET);
			test_q <= TEST_RESET;
			pga_q <= 8'h01;
			half_q <= 1'b0;
			clock_output_pin_q <= 1'b0;
		end
		else
		begin
			setup_q <= setup_d;
			clock_q <= clock_d;
			test_q <= test_d;
			pga_q <= pga_d;
			half_q <= half_d;
			clock_output_pin_q <= clock_output_pin_d;
		end
	end

	// ==========================================================
	// Conversion timing and calibration
	assign tick = ~clock_q.input_clock_halve | half_q;
	// Word period from rate family and filter rate
	assign period = 24'(CONV_SCALE * int'(DEC_RATE[{clock_q.rate_family_select, clock_q.filter_rate_select}]));
	assign cal_request = wr_stb && cmd_q.register_select == REG_SETUP && wr_word[7:6] != MODE_NORMAL;
	assign pair = pair_of(cal_ch_q);

	ascdr_conv_timer u_timer (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.tick_in(tick),
		.restart_in(wr_stb && cmd_q.register_select == REG_SETUP),
		.hold_in(setup_q.filter_sync_hold),
		.period_in(period),
		.done_out(conv_done)
	);

	always_comb
	begin
		cal_d = cal_q;
		cal_self_d = cal_self_q;
		cal_ch_d = cal_ch_q;
		result_d = result_q;
		data_ready_n_d = data_ready_n_q;
		offset_d = offset_q;
		gain_d = gain_q;
		cal_finish = 1'b0;
		if (wr_stb && cmd_q.register_select == REG_OFFSET)
			offset_d[pair_of(cmd_q.channel_select)] = wr_word;
		if (wr_stb && cmd_q.register_select == REG_GAIN)
			gain_d[pair_of(cmd_q.channel_select)] = wr_word;
		if (data_read_done)
			data_ready_n_d = 1'b1;
		if (conv_done)
		begin
			case (cal_q)
				CAL_RUN:
				begin
					result_d = format_result(analog_code_in, offset_q[pair_of(cmd_q.channel_select)],
						setup_q.polarity_select);
					data_ready_n_d = 1'b0;
				end
				CAL_ZERO:
				begin
					offset_d[pair] = {analog_code_in, 8'h00};
					if (cal_self_q)
						cal_d = CAL_FULL;
					else
					begin
						cal_d = CAL_RUN;
						cal_finish = 1'b1;
						result_d = format_result(analog_code_in, {analog_code_in, 8'h00}, setup_q.polarity_select);
						data_ready_n_d = 1'b0;
					end
				end
				CAL_FULL:
				begin
					gain_d[pair] = {analog_code_in, 8'h00};
					cal_d = CAL_RUN;
					cal_finish = 1'b1;
					result_d = format_result(analog_code_in, offset_d[pair], setup_q.polarity_select);
					data_ready_n_d = 1'b0;
				end
				default: cal_d = CAL_RUN;
			endcase
		end
		if (cal_request)
		begin
			cal_d = (wr_word[7:6] == MODE_SYS_FULL) ? CAL_FULL : CAL_ZERO;
			cal_self_d = (wr_word[7:6] == MODE_SELF);
			cal_ch_d = cmd_q.channel_select;
			data_ready_n_d = 1'b1;
		end
		short_d = (cal_d == CAL_ZERO) && cal_self_d;
		fsref_d = (cal_d == CAL_FULL) && cal_self_d;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			cal_q <= CAL_RUN;
			cal_self_q <= 1'b0;
			cal_ch_q <= 2'h0;
			result_q <= 16'h0000;
			data_ready_n_q <= 1'b1;
			short_q <= 1'b0;
			fsref_q <= 1'b0;
			offset_q <= '{OFFSET_RESET, OFFSET_RESET, OFFSET_RESET};
			gain_q <= '{GAIN_RESET, GAIN_RESET, GAIN_RESET};
		end
		else
		begin
			cal_q <= cal_d;
			cal_self_q <= cal_self_d;
			cal_ch_q <= cal_ch_d;
			result_q <= result_d;
			data_ready_n_q <= data_ready_n_d;
			short_q <= short_d;
			fsref_q <= fsref_d;
			offset_q <= offset_d;
			gain_q <= gain_d;
		end
	end

	// ==========================================================
	// Outputs
	assign serial_data_out = dout_q;
	assign data_ready_n_out = data_ready_n_q;
	assign clock_output_pin_out = clock_output_pin_q;
	assign channel_select_out = cmd_q.channel_select;
	assign pga_gain_out = pga_q;
	assign input_buffer_enable_out = setup_q.input_buffer_enable;
	assign input_short_out = short_q;
	assign full_scale_ref_out = fsref_q;
	assign modulator_hold_out = setup_q.filter_sync_hold;
	assign power_down_out = cmd_q.power_down;

	// ==========================================================
	// Assertions
	reset_values_a: assert property (@(posedge ref_clk_in) !rst_n_in |=>
		(setup_q == SETUP_RESET && clock_q == CLOCK_RESET))
		else $error("register reset values wrong");
	zero_bits_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_stb && cmd_q.register_select == REG_CLOCK) |=> clock_q.fixed_zero == 2'h0)
		else $error("fixed zero clock bits changed");
	mode_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(cal_finish && !wr_stb) |=> (setup_q.mode_select_bits == MODE_NORMAL && cal_q == CAL_RUN))
		else $error("mode bits not cleared after calibration");
	cal_busy_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		cal_request |=> (data_ready_n_q && data_ready_n_out) until (cal_q == CAL_RUN))
		else $error("ready flag low during calibration");
	self_step_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(conv_done && cal_q == CAL_ZERO && cal_self_q && !cal_request)
		|=> (cal_q == CAL_FULL && full_scale_ref_out && !input_short_out))
		else $error("self calibration skipped full scale step");
	sys_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(conv_done && cal_q == CAL_ZERO && !cal_self_q && !cal_request && !wr_stb)
		|=> (offset_q[pair] == {$past(analog_code_in), 8'h00} && $stable(gain_q[pair]) && !data_ready_n_q))
		else $error("zero scale calibration result wrong");
	pga_decode_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$changed(setup_q.gain_code) |-> pga_gain_out == (8'h01 << setup_q.gain_code))
		else $error("amplifier gain decode wrong");
	clock_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		clock_q.clock_output_disable |=> !clock_output_pin_out)
		else $error("clock pin not held low");
	clock_halve_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(clock_q.input_clock_halve && $past(clock_q.input_clock_halve)) |-> (tick != $past(tick)))
		else $error("master clock not halved");
	data_discard_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(wr_stb && cmd_q.register_select == REG_DATA && !conv_done) |=> ($stable(result_q) && ser_q == SER_CMD))
		else $error("data register write not discarded");
	dout_edge_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$changed(serial_data_out) |-> $past(sclk_fall))
		else $error("serial output changed off a falling edge");
	bipolar_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(conv_done && cal_q == CAL_RUN && !cal_request && !setup_q.polarity_select
		&& analog_code_in == offset_q[pair_of(cmd_q.channel_select)][23:8]) |=> result_q == BIPOLAR_ZERO)
		else $error("bipolar zero code wrong");
	sync_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(setup_q.filter_sync_hold && $past(setup_q.filter_sync_hold)) |-> !conv_done)
		else $error("conversion finished while held");

endmodule

//--- tb/ascdr_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module ascdr_bench;
	import ascdr_pkg::*;
	logic ref_clk_in;
	logic rst_n_in;
	logic sclk;
	logic sdin;
	logic csn;
	logic sdout;
	logic rdy_n;
	logic clk_pin;
	logic c1;
	logic [15:0] analog;
	logic [1:0] chan;
	logic [7:0] gain;
	logic buf_en, in_short, fs_ref, mod_hold, pwr_dn;
	int error_cnt = 0;
	int tests_run = 0;

	ascdr_top #(.CONV_SCALE(1)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .serial_clk_in(sclk),
		.serial_data_in(sdin), .chip_select_n_in(csn), .serial_data_out(sdout), .data_ready_n_out(rdy_n),
		.clock_output_pin_out(clk_pin), .analog_code_in(analog), .channel_select_out(chan),
		.pga_gain_out(gain), .input_buffer_enable_out(buf_en), .input_short_out(in_short),
		.full_scale_ref_out(fs_ref), .modulator_hold_out(mod_hold), .power_down_out(pwr_dn));

	ascdr_host host (.ref_clk_in(ref_clk_in), .serial_data_out(sdout), .serial_clk_in(sclk),
		.serial_data_in(sdin), .chip_select_n_in(csn));

	// ====
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [23:0] w, input int n);
		logic [23:0] r;
		host.xfer({16'h0000, cmd}, 8, r);
		host.xfer(w, n, r);
	endtask

	task automatic rd(input logic [7:0] cmd, input int n, input logic [23:0] exp);
		logic [23:0] r;
		host.xfer({16'h0000, cmd}, 8, r);
		host.xfer(24'h00_0000, n, r);
		check(r, exp);
	endtask

	task automatic wait_rdy(input logic lvl);
		int i;
		for (i = 0; i < 3000 && rdy_n !== lvl; i++)
			step(1);
		if (i == 3000)
		begin
			error_cnt++;
			$display("unexpected at %0t: ready wait ran out", $time);
			wrap_up();
		end
	endtask

	initial
	begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end

	initial
	begin
		repeat (90000) @(posedge ref_clk_in);
		error_cnt++;
		$display("unexpected at %0t: run limit reached", $time);
		wrap_up();
	end

	// ====
	// Main sequence
	initial
	begin
		rst_n_in = 1'b0;
		analog = 16'h3000;
		step(8);
		rst_n_in = 1'b1;
		step(4);
		check({16'h0000, gain}, 24'h00_0001);
		check({21'h00_0000, mod_hold, buf_en, pwr_dn}, 24'h00_0004);
		rd(8'h18, 8, 24'h00_0001);
		rd(8'h28, 8, 24'h00_0005);
		wr(8'h20, 24'h00_00ff, 8);
		rd(8'h28, 8, 24'h00_001f);
		for (int i = 0; i < 4; i++)
		begin
			step(1);
			check({23'h00_0000, clk_pin}, 24'h00_0000);
		end
		// Rate family 1, filter rate 11; calibrations follow
		wr(8'h20, 24'h00_0007, 8);
		step(1);
		c1 = clk_pin;
		step(1);
		check({23'h00_0000, clk_pin}, {23'h00_0000, ~c1});
		for (int g = 0; g < 8; g++)
		begin
			wr(8'h10, {16'h0000, 2'b00, g[2:0], 3'b011}, 8);
			check({16'h0000, gain}, {16'h0000, 8'h01 << g});
		end
		check({21'h00_0000, mod_hold, buf_en, pwr_dn}, 24'h00_0006);
		wr(8'h30, 24'h00_a5a5, 16);
		rd(8'h18, 8, 24'h00_003b);
		wr(8'h10, 24'h00_0004, 8);
		check({21'h00_0000, mod_hold, buf_en, pwr_dn}, 24'h00_0000);
		wait_rdy(1'b0);
		rd(8'h38, 16, 24'h00_10c0);
		wr(8'h10, 24'h00_0000, 8);
		step(80);
		rd(8'h38, 16, 24'h00_20c0);
		analog = 16'h2222;
		wr(8'h11, 24'h00_0080, 8);
		check({23'h00_0000, rdy_n}, 24'h00_0001);
		check({22'h00_0000, chan}, 24'h00_0001);
		wait_rdy(1'b0);
		rd(8'h19, 8, 24'h00_0000);
		rd(8'h6d, 24, 24'h22_2200);
		rd(8'h7d, 24, 24'h57_61ab);
		analog = 16'h4444;
		wr(8'h11, 24'h00_00c0, 8);
		wait_rdy(1'b0);
		rd(8'h19, 8, 24'h00_0000);
		rd(8'h7d, 24, 24'h44_4400);
		rd(8'h6d, 24, 24'h22_2200);
		analog = 16'h3000;
		wr(8'h11, 24'h00_0044, 8);
		check({23'h00_0000, rdy_n}, 24'h00_0001);
		check({22'h00_0000, in_short, fs_ref}, 24'h00_0002);
		step(50);
		check({22'h00_0000, in_short, fs_ref}, 24'h00_0001);
		wait_rdy(1'b0);
		check({22'h00_0000, in_short, fs_ref}, 24'h00_0000);
		rd(8'h19, 8, 24'h00_0004);
		rd(8'h6d, 24, 24'h30_0000);
		rd(8'h7d, 24, 24'h30_0000);
		wr(8'h11, 24'h00_0005, 8);
		rd(8'h39, 16, 24'h00_0000);
		step(120);
		check({23'h00_0000, rdy_n}, 24'h00_0001);
		rd(8'h1d, 8, 24'h00_0005);
		check({23'h00_0000, pwr_dn}, 24'h00_0001);
		wrap_up();
	end
endmodule

//--- tb/ascdr_host.sv
// Host model driving the three-wire serial port of the converter
`timescale 1ns/1ps
module ascdr_host
(
	// Clock
	input wire logic ref_clk_in,
	// Serial port
	input wire logic serial_data_out,
	output logic serial_clk_in,
	output logic serial_data_in,
	output logic chip_select_n_in
);
	// ====
	// Idle: clock high and still, chip deselected
	initial
	begin
		serial_clk_in = 1'b1;
		serial_data_in = 1'b1;
		chip_select_n_in = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	// ====
	// One phase of n bits, MSB first, read bit taken at each rising edge
	// Only command-then-transfer pairs are sent; the test register is never written
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
		r = 24'h00_0000;
		wait_clk(1);
		chip_select_n_in = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			wait_clk(2);
			serial_clk_in = 1'b0;
			serial_data_in = w[i];
			wait_clk(6);
			r = {r[22:0], serial_data_out};
			serial_clk_in = 1'b1;
			wait_clk(4);
		end
		wait_clk(2);
		chip_select_n_in = 1'b1;
		// Released line shows the inverse of its last value
		serial_data_in = ~serial_data_in;
	endtask
endmodule
